// File: logic/fla_lookahead_map.vh
/*
  holds the address layout, fetch timing and state codes for the
  flash look-ahead read sequencer.
  assumes the requester drives address and read controls in the clk domain.
*/
// Summary of operation
// - read with look-ahead request held enters look-ahead mode
// - while buffer is read, next block fetches from array in background
// - block not last in page: fetch next linear block in same page
// - last data block of page: fetch first block of next page
// - spare page read: fetch first block of next sector's spare page
// - highest sector wraps so next fetch comes from sector 0
// - auxiliary block read: fetch auxiliary block of next linear page
// - mismatch finishes running fetch first, busy held meanwhile
// - mismatch busy lasts at most nine cycles before data delivered
`ifndef FLA_LOOKAHEAD_MAP_VH
`define FLA_LOOKAHEAD_MAP_VH

// ==========================================================
// address fields
`define FLA_BLK_W 2
`define FLA_PAGE_W 4
`define FLA_SECT_W 4

// ==========================================================
// timing
`define FLA_FETCH_CYCLES 4
`define FLA_BUSY_MAX 9

// ==========================================================
// states, one-hot
`define FLA_ST_IDLE 4'h1
`define FLA_ST_FETCH 4'h2
`define FLA_ST_READY 4'h4
`define FLA_ST_DRAIN 4'h8

`endif

// File: logic/fla_lookahead_read_addr.v
/*
  look-ahead read address generator and busy sequencer for the
  embedded_flash_unit block buffer.
  assumes the requester holds address and readRequest steady while busy.
*/
`include "fla_lookahead_map.vh"

module fla_lookahead_read_addr #(
  parameter BLK_W = `FLA_BLK_W,
  parameter PAGE_W = `FLA_PAGE_W,
  parameter SECT_W = `FLA_SECT_W,
  parameter FETCH_CYCLES = `FLA_FETCH_CYCLES
) (
  input wire clk,
  input wire sys_rst,
  input wire readRequest,
  input wire lookaheadReadRequest,
  input wire spareSelect,
  input wire auxSelect,
  input wire [SECT_W+PAGE_W+BLK_W-1:0] readAddr,
  output reg busy_q,
  output reg dataValid_q,
  output reg lookaheadActive_q,
  output reg arrayFetch_q,
  output reg [SECT_W+PAGE_W+BLK_W-1:0] fetchAddr_q,
  output reg fetchSpare_q,
  output reg fetchAux_q
);

  localparam AW = SECT_W + PAGE_W + BLK_W;
  localparam [3:0] ST_IDLE = `FLA_ST_IDLE;
  localparam [3:0] ST_FETCH = `FLA_ST_FETCH;
  localparam [3:0] ST_READY = `FLA_ST_READY;
  localparam [3:0] ST_DRAIN = `FLA_ST_DRAIN;
  localparam [3:0] FETCH_LAST = FETCH_CYCLES - 1;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [3:0] cnt_q;
  reg [AW-1:0] nextAddr;
  reg [AW-1:0] bufAddr_q;
  reg bufSpare_q;
  reg bufAux_q;
  wire [BLK_W-1:0] blk;
  wire [PAGE_W-1:0] page;
  wire [SECT_W-1:0] sect;
  wire lastBlk;
  wire hit;

  assign blk = bufAddr_q[BLK_W-1:0];
  assign page = bufAddr_q[PAGE_W+BLK_W-1:BLK_W];
  assign sect = bufAddr_q[AW-1:PAGE_W+BLK_W];
  assign lastBlk = &blk;
  // predicted address must agree with the pending fetch target
  assign hit = (readAddr == fetchAddr_q) && (spareSelect == fetchSpare_q)
    && (auxSelect == fetchAux_q);

  // ==========================================================
  // look-ahead address prediction
  always @*
  begin
    nextAddr = bufAddr_q;
    if (bufAux_q)
    begin
      nextAddr = bufAddr_q + {{(AW-BLK_W-1){1'b0}}, 1'b1, {BLK_W{1'b0}}};
    end
    else if (bufSpare_q)
    begin
      // sector field overflows to zero on its own at the top
      nextAddr = {sect + 1'b1, {PAGE_W{1'b0}}, {BLK_W{1'b0}}};
    end
    else if (!lastBlk)
    begin
      nextAddr = {sect, page, blk + 1'b1};
    end
    else
    begin
      // carry out of the page field moves to the next sector, wrapping
      nextAddr = {bufAddr_q[AW-1:BLK_W] + 1'b1, {BLK_W{1'b0}}};
    end
  end

  // ==========================================================
  // sequencer
  // a miss seen while a background fetch is still running must let that
  // fetch finish first; the drain state only covers the cycles that are
  // left of it, so the counter keeps running into drain.
  // a miss seen once the buffer is ready costs one plain fetch, since
  // nothing is in flight any more.
  // worst case is a miss on the first background cycle: the rest of the
  // running fetch plus one full fetch, well inside the busy limit.
  // a request equal to the block in flight simply waits for it, with no
  // busy, and is then served from the buffer as a hit.
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (readRequest)
          state_d = ST_FETCH;
      ST_FETCH:
        if (cnt_q == FETCH_LAST)
          state_d = ST_READY;
        else if (readRequest && !busy_q && !hit)
          state_d = ST_DRAIN;
      ST_READY:
        if (readRequest && !hit)
          state_d = ST_FETCH;
        else if (readRequest && hit && lookaheadReadRequest)
          state_d = ST_FETCH;
        else if (readRequest)
          state_d = ST_FETCH;
      ST_DRAIN:
        if (cnt_q == FETCH_LAST)
          state_d = ST_FETCH;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      bufAddr_q <= {AW{1'b0}};
      bufSpare_q <= 1'b0;
      bufAux_q <= 1'b0;
      busy_q <= 1'b0;
      dataValid_q <= 1'b0;
      lookaheadActive_q <= 1'b0;
      arrayFetch_q <= 1'b0;
      fetchAddr_q <= {AW{1'b0}};
      fetchSpare_q <= 1'b0;
      fetchAux_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      dataValid_q <= 1'b0;
      // drain continues the count of the fetch it waits for
      cnt_q <= (state_d != state_q && state_d != ST_DRAIN) ? 4'h0
        : cnt_q + 4'h1;
      case (state_q)
        ST_IDLE:
          if (readRequest)
          begin
            fetchAddr_q <= readAddr;
            fetchSpare_q <= spareSelect;
            fetchAux_q <= auxSelect;
            arrayFetch_q <= 1'b1;
            busy_q <= 1'b1;
            lookaheadActive_q <= lookaheadReadRequest;
          end
        ST_FETCH:
          if (cnt_q == FETCH_LAST)
          begin
            // fetched block lands in the buffer, data goes out if awaited
            bufAddr_q <= fetchAddr_q;
            bufSpare_q <= fetchSpare_q;
            bufAux_q <= fetchAux_q;
            arrayFetch_q <= 1'b0;
            dataValid_q <= busy_q;
            busy_q <= 1'b0;
          end
          else if (readRequest && !busy_q && !hit)
          begin
            // miss during a background fetch: wait it out, busy meanwhile
            busy_q <= 1'b1;
            lookaheadActive_q <= lookaheadReadRequest;
          end
        ST_READY:
          if (readRequest && hit)
          begin
            // hit served from the buffer without wait states
            dataValid_q <= 1'b1;
            bufAddr_q <= fetchAddr_q;
            bufSpare_q <= fetchSpare_q;
            bufAux_q <= fetchAux_q;
            lookaheadActive_q <= lookaheadReadRequest;
            arrayFetch_q <= 1'b1;
            fetchAddr_q <= nextAddr;
          end
          else if (readRequest)
          begin
            // nothing in flight here, so the requested block starts at once
            fetchAddr_q <= readAddr;
            fetchSpare_q <= spareSelect;
            fetchAux_q <= auxSelect;
            busy_q <= 1'b1;
            arrayFetch_q <= 1'b1;
            lookaheadActive_q <= lookaheadReadRequest;
          end
        ST_DRAIN:
          if (cnt_q == FETCH_LAST)
          begin
            // background fetch done, start the requested block
            fetchAddr_q <= readAddr;
            fetchSpare_q <= spareSelect;
            fetchAux_q <= auxSelect;
          end
        default:
          busy_q <= 1'b0;
      endcase
      // prediction tracks the kind of block now in the buffer
      if (state_q == ST_READY && readRequest && hit)
      begin
        fetchSpare_q <= fetchSpare_q;
        fetchAux_q <= fetchAux_q;
      end
    end
  end

endmodule // fla_lookahead_read_addr

// File: verif/fla_lookahead_assertions.sv
/* checker for the look-ahead read sequencer.
   assumes it is bound to the sequencer top, one clk domain. */
module fla_lookahead_assertions (
  input wire clk,
  input wire sys_rst,
  input wire readRequest,
  input wire lookaheadReadRequest,
  input wire spareSelect,
  input wire auxSelect,
  input wire [9:0] readAddr,
  input wire busy_q,
  input wire dataValid_q,
  input wire lookaheadActive_q,
  input wire arrayFetch_q,
  input wire [9:0] fetchAddr_q,
  input wire fetchSpare_q,
  input wire fetchAux_q
);
  // ==========
  // request matching the prediction while nothing runs
  wire hit = readRequest && lookaheadReadRequest && !busy_q && !arrayFetch_q
    && lookaheadActive_q && readAddr == fetchAddr_q
    && spareSelect == fetchSpare_q && auxSelect == fetchAux_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_busy_max:
    assert property ($rose(busy_q) |-> ##[1:9] dataValid_q) else $error("late");
  a_valid_pulse:
    assert property (dataValid_q |=> !dataValid_q) else $error("long pulse");
  a_miss_busy:
    assert property (readRequest && !busy_q && !arrayFetch_q && !hit |=> busy_q)
    else $error("miss not busy");
  a_busy_release:
    assert property ($fell(busy_q) |-> dataValid_q) else $error("busy drop");
  a_hit_fast:
    assert property (hit |=> dataValid_q && !busy_q && arrayFetch_q)
    else $error("hit slow");
  a_next_linear:
    assert property (hit && !spareSelect && !auxSelect |=>
      fetchAddr_q == $past(readAddr) + 10'h001) else $error("linear");
  a_spare_next:
    assert property (hit && spareSelect |=> fetchSpare_q && fetchAddr_q[1:0]
      == 2'h0 && fetchAddr_q[9:6] == $past(readAddr[9:6]) + 4'h1)
    else $error("spare");
  a_aux_next:
    assert property (hit && auxSelect |=> fetchAux_q
      && fetchAddr_q[9:2] == $past(readAddr[9:2]) + 8'h01) else $error("aux");
endmodule // fla_lookahead_assertions
bind fla_lookahead_read_addr fla_lookahead_assertions chk (.*);

// File: verif/fla_requester.sv
/* user-side requester model for the look-ahead sequencer.
   assumes one clk domain; drives at the falling edge. */
module fla_requester (
  input wire clk,
  input wire dataValid_q,
  output logic readRequest,
  output logic lookaheadReadRequest,
  output logic spareSelect,
  output logic auxSelect,
  output logic [9:0] readAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // request held until data arrives, busy simply waited out
  initial
    {readAddr, spareSelect, auxSelect, lookaheadReadRequest, readRequest} = 14'h0;
  task automatic rd(input logic [9:0] a, input logic sp, ax, output int lat);
    lat = 0;
    @(negedge clk);
    {readAddr, spareSelect, auxSelect, lookaheadReadRequest, readRequest} =
      {a, sp, ax, 2'h3};
    do
    begin
      @(posedge clk);
      #1 lat++;
    end while (!dataValid_q && lat < 30);
    @(negedge clk);
    readRequest = 1'b0;
    readAddr = ~a; // released address must not look valid
  endtask
endmodule // fla_requester

// File: verif/testbench.sv
/* self-checking bench for the look-ahead read sequencer.
   assumes the requester model and bound checker are compiled with it. */
`define CHK(g, e) checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst;
  wire readRequest, lookaheadReadRequest, spareSelect, auxSelect, busy_q;
  wire dataValid_q, lookaheadActive_q, arrayFetch_q, fetchSpare_q, fetchAux_q;
  wire [9:0] readAddr, fetchAddr_q;
  int fail_count = 0, checks_done = 0, lat, seed = 32'hA320;
  logic [9:0] a, k;
  fla_lookahead_read_addr uut (.*);
  fla_requester req (.*);
  // ==========
  // successor; spare page and aux block fields are masked off as open
  function logic [9:0] nxt(input logic [9:0] x, input int m);
    nxt = m == 1 ? {x[9:6] + 4'h1, 6'h0} : m == 2 ? {x[9:2] + 8'h01, 2'h0}
      : x + 10'h001;
  endfunction
  task wrap_up();
    $display("mismatches %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #100000; // over eight times the expected traffic
    fail_count++;
    wrap_up();
  end
  initial
  begin
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    for (int m = 0; m < 3; m++)
      for (int i = 0; i < 5; i++)
      begin
        k = m == 1 ? 10'h3C3 : m == 2 ? 10'h3FC : 10'h3FF;
        a = i == 0 ? 10'h3FD : 10'($random(seed)); // top: page end and wrap
        req.rd(a, m == 1, m == 2, lat);
        `CHK(lat <= 9, 1'b1)
        repeat (3)
        begin
          req.rd(a, m == 1, m == 2, lat);
          `CHK(arrayFetch_q & lookaheadActive_q, 1'b1)
          `CHK(fetchAddr_q & k, nxt(a, m) & k)
          `CHK({fetchSpare_q, fetchAux_q}, {m == 1, m == 2})
          `CHK(busy_q, 1'b0)
          a = fetchAddr_q;
        end
      end
    wrap_up();
  end
endmodule // testbench
